// ---- src/mpc_pkg.sv ----
package mpc_pkg;

    localparam logic [7:0] ADDR_CFG      = 8'h12;
    localparam logic [7:0] ADDR_INT_STAT = 8'h20;
    localparam logic [7:0] ADDR_INT_EN   = 8'h21;
    localparam logic [7:0] ADDR_INT_CLR  = 8'h22;
    localparam logic [7:0] ADDR_FAULT    = 8'h23;
    localparam logic [7:0] ADDR_LEAD     = 8'h24;

    localparam int BIT_DUTY_REDUCE = 7;
    localparam int BIT_HALL_INV = 5;
    localparam int BIT_INTERP   = 4;
    localparam int BIT_LOCK_LF  = 2;
    localparam int BIT_OC_LF    = 1;

    localparam logic [7:0] CFG_RESET     = 8'h10;
    localparam logic [7:0] CFG_WRITABLE  = 8'hB6;

    localparam int IRQ_OC_SET   = 0;
    localparam int IRQ_LOCK_SET = 1;
    localparam int IRQ_LATCHED  = 2;
    localparam logic [7:0] IRQ_MASK = 8'h07;

    localparam int DUTY_W = 8;
    localparam logic [7:0] OC_DUTY_LIMIT = 8'h80;

    typedef struct packed {
        logic [7:0] address;
        logic       read;
        logic       write;
        logic [31:0] writedata;
    } mpc_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } mpc_bus_rsp_t;

endpackage

// ---- src/mpc_fault_latch.sv ----
`timescale 1ns/1ps
module mpc_fault_latch (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic fault,
    input  wire logic latch_en,
    input  wire logic reinit,
    output logic      latched,
    output logic      disable_out
);
    typedef struct packed {
        logic q;
    } mpc_fl_state_t;

    mpc_fl_state_t st;
    mpc_fl_state_t next_st;

    always_comb begin
        next_st = st;
        // a fault in the reinit cycle still latches: set beats clear
        if (reinit) begin
            next_st.q = 1'b0;
        end
        if (fault && latch_en) begin
            next_st.q = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign latched     = st.q;
    // fault response: outputs off while the fault is present or while the latch is set
    assign disable_out = st.q | fault;
endmodule

// ---- src/mpc_motor_protect_config_reg.sv ----
`timescale 1ns/1ps
module mpc_motor_protect_config_reg #(
    parameter int DUTY_W = mpc_pkg::DUTY_W
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  otp_load,
    input  wire logic [7:0]            otp_value,
    input  wire logic [2:0]            hall_in,
    input  wire logic                  overcurrent_in,
    input  wire logic                  rotor_lock_in,
    input  wire logic [DUTY_W-1:0]     duty_in,
    input  wire logic [DUTY_W-1:0]     lead_angle_comp_setting,
    input  wire logic                  reinit,
    output logic [2:0]                 hall_out,
    output logic [DUTY_W-1:0]          duty_out,
    output logic [2*DUTY_W-1:0]        lead_angle,
    output logic                       outputs_disable,
    output logic                       irq
);
    typedef struct packed {
        logic [7:0]          cfg;
        logic [2:0]          hall_s1;
        logic [2:0]          hall_s2;
        logic [1:0]          oc_s;
        logic [1:0]          lock_s;
        logic                oc_prev;
        logic                lock_prev;
        logic [7:0]          int_stat;
        logic [7:0]          int_en;
        logic                ack;
        logic [31:0]         rdata;
        logic [2:0]          hall_q;
        logic [DUTY_W-1:0]   duty_q;
        logic [2*DUTY_W-1:0] lead_q;
        logic                dis_q;
        logic                irq_q;
        logic                latch_prev;
    } mpc_state_t;

    mpc_state_t st;
    mpc_state_t next_st;

    logic oc_latched;
    logic oc_disable;
    logic lock_latched;
    logic lock_disable;

    function automatic logic [31:0] mpc_zext8(input logic [7:0] v);
        mpc_zext8 = {24'h000000, v};
    endfunction

    mpc_fault_latch u_oc_latch (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .fault       (st.oc_s[1]),
        .latch_en    (st.cfg[mpc_pkg::BIT_OC_LF]),
        .reinit      (reinit),
        .latched     (oc_latched),
        .disable_out (oc_disable)
    );

    mpc_fault_latch u_lock_latch (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .fault       (st.lock_s[1]),
        .latch_en    (st.cfg[mpc_pkg::BIT_LOCK_LF]),
        .reinit      (reinit),
        .latched     (lock_latched),
        .disable_out (lock_disable)
    );

    always_comb begin
        logic [7:0]  ev;
        logic [7:0]  clr;
        logic        is_wr;
        logic        is_rd;
        ev    = 8'h00;
        clr   = 8'h00;
        // writes land on the acknowledge edge; read data is loaded on the
        // request edge so it stands while waitrequest is low
        is_wr = avs_write && st.ack;
        is_rd = avs_read && !st.ack;
        next_st = st;

        // two-flop synchronisers for pins
        next_st.hall_s1 = hall_in;
        next_st.hall_s2 = st.hall_s1;
        next_st.oc_s    = {st.oc_s[0], overcurrent_in};
        next_st.lock_s  = {st.lock_s[0], rotor_lock_in};
        next_st.oc_prev   = st.oc_s[1];
        next_st.lock_prev = st.lock_s[1];

        // one-cycle answer: waitrequest low one cycle after request
        next_st.ack = (avs_read || avs_write) && !st.ack;
        next_st.latch_prev = oc_latched | lock_latched;

        if (otp_load) begin
            next_st.cfg = otp_value & mpc_pkg::CFG_WRITABLE;
        end
        if (is_wr) begin
            case (avs_address)
                mpc_pkg::ADDR_CFG: begin
                    next_st.cfg = avs_writedata[7:0]
                                  & mpc_pkg::CFG_WRITABLE;
                end
                mpc_pkg::ADDR_INT_EN: begin
                    next_st.int_en = avs_writedata[7:0] & mpc_pkg::IRQ_MASK;
                end
                mpc_pkg::ADDR_INT_CLR: begin
                    clr = avs_writedata[7:0];
                end
                default: begin
                    next_st.int_en = next_st.int_en;
                end
            endcase
        end

        if (is_rd) begin
            case (avs_address)
                mpc_pkg::ADDR_CFG:      next_st.rdata = mpc_zext8(st.cfg);
                mpc_pkg::ADDR_INT_STAT: next_st.rdata = mpc_zext8(st.int_stat);
                mpc_pkg::ADDR_INT_EN:   next_st.rdata = mpc_zext8(st.int_en);
                mpc_pkg::ADDR_FAULT: begin
                    next_st.rdata = {30'h0000000, lock_latched, oc_latched};
                end
                mpc_pkg::ADDR_LEAD: begin
                    next_st.rdata = 32'(st.lead_q);
                end
                default:                next_st.rdata = 32'h00000000;
            endcase
        end

        // events: rising edges of faults and entry into latch-off
        ev[mpc_pkg::IRQ_OC_SET]   = st.oc_s[1] && !st.oc_prev;
        ev[mpc_pkg::IRQ_LOCK_SET] = st.lock_s[1] && !st.lock_prev;
        ev[mpc_pkg::IRQ_LATCHED]  = (oc_latched | lock_latched)
                                    && !st.latch_prev;
        // set wins over clear
        next_st.int_stat = (st.int_stat & ~clr) | ev;
        next_st.irq_q    = |(next_st.int_stat & next_st.int_en);

        next_st.hall_q = st.cfg[mpc_pkg::BIT_HALL_INV]
                         ? ~st.hall_s2 : st.hall_s2;

        if (st.cfg[mpc_pkg::BIT_DUTY_REDUCE] && st.oc_s[1]
            && duty_in > DUTY_W'(mpc_pkg::OC_DUTY_LIMIT)) begin
            next_st.duty_q = DUTY_W'(mpc_pkg::OC_DUTY_LIMIT);
        end else begin
            next_st.duty_q = duty_in;
        end

        if (st.cfg[mpc_pkg::BIT_INTERP]) begin
            next_st.lead_q = duty_in * lead_angle_comp_setting;
        end else begin
            // fixed angle: setting scaled as full duty
            next_st.lead_q = {lead_angle_comp_setting,
                              {DUTY_W{1'b0}}};
        end

        next_st.dis_q = oc_disable | lock_disable;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st       <= '0;
            st.cfg   <= mpc_pkg::CFG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = !st.ack;
    assign hall_out        = st.hall_q;
    assign duty_out        = st.duty_q;
    assign lead_angle      = st.lead_q;
    assign outputs_disable = st.dis_q;
    assign irq             = st.irq_q;
endmodule

// ---- testbench/mpc_chk.sv ----
`timescale 1ns/1ps
module mpc_chk #(parameter int DUTY_W = 8) (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic [7:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic                avs_waitrequest,
    input wire logic                otp_load,
    input wire logic [7:0]          otp_value,
    input wire logic [2:0]          hall_in,
    input wire logic                overcurrent_in,
    input wire logic [DUTY_W-1:0]   duty_in,
    input wire logic [DUTY_W-1:0]   lead_angle_comp_setting,
    input wire logic [2:0]          hall_out,
    input wire logic [DUTY_W-1:0]   duty_out,
    input wire logic [2*DUTY_W-1:0] lead_angle,
    input wire logic                outputs_disable,
    input wire logic                irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0]          sh;
    logic [3:0]          age;
    logic [2*DUTY_W-1:0] e_lead;
    logic [DUTY_W-1:0]   e_duty;
    // shadow of the config register, rebuilt from bus and otp traffic
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sh <= mpc_pkg::CFG_RESET;
            age <= 4'h0;
        end else begin
            age <= age + {3'h0, age != 4'hF};
            if (avs_write && !avs_waitrequest
                && avs_address == mpc_pkg::ADDR_CFG)
                sh <= avs_writedata[7:0] & mpc_pkg::CFG_WRITABLE;
            else if (otp_load)
                sh <= otp_value & mpc_pkg::CFG_WRITABLE;
        end
    end
    always_comb begin
        e_lead = sh[mpc_pkg::BIT_INTERP]
                 ? duty_in * lead_angle_comp_setting
                 : {lead_angle_comp_setting, {DUTY_W{1'h0}}};
        e_duty = (sh[mpc_pkg::BIT_DUTY_REDUCE] && overcurrent_in
                  && duty_in > mpc_pkg::OC_DUTY_LIMIT)
                 ? mpc_pkg::OC_DUTY_LIMIT : duty_in;
    end
    property p_ack;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_one: assert property (p_one) else $error("long ack");
    property p_idle;
        !avs_read && !avs_write |=> avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("idle ack");
    // guards keep synchronizer latency from comparing stale inputs
    property p_hall;
        age == 4'hF && sh == $past(sh, 3)
        |-> hall_out == ($past(hall_in, 3)
                         ^ {3{sh[mpc_pkg::BIT_HALL_INV]}});
    endproperty
    a_hall: assert property (p_hall) else $error("hall");
    property p_lead;
        age == 4'hF |-> lead_angle == $past(e_lead);
    endproperty
    a_lead: assert property (p_lead) else $error("lead");
    property p_duty;
        age == 4'hF && overcurrent_in == $past(overcurrent_in, 4)
        |-> duty_out == $past(e_duty);
    endproperty
    a_duty: assert property (p_duty) else $error("duty");
    property p_dis;
        overcurrent_in [*5] |-> outputs_disable;
    endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_rst;
        $fell(rst) |-> avs_waitrequest && !irq && hall_out == 3'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    c_wr: cover property (avs_write && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
    c_lat: cover property (outputs_disable && !overcurrent_in);
endmodule
bind mpc_motor_protect_config_reg mpc_chk #(.DUTY_W(DUTY_W)) i_mpc_chk (.*);

// ---- testbench/mpc_motor_protect_config_reg_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module mpc_motor_protect_config_reg_tb_top;
    logic        clk_sys = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        otp_load = 1'h0;
    logic [7:0]  otp_value = 8'h00;
    logic [2:0]  hall_in = 3'h5;
    logic        overcurrent_in = 1'h0;
    logic        rotor_lock_in = 1'h0;
    logic [7:0]  duty_in = 8'h03;
    logic [7:0]  lead_angle_comp_setting = 8'h05;
    logic        reinit = 1'h0;
    logic [2:0]  hall_out;
    logic [7:0]  duty_out;
    logic [15:0] lead_angle;
    logic        outputs_disable;
    logic        irq;
    logic [31:0] rv;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #5 clk_sys = ~clk_sys;
    mpc_motor_protect_config_reg i_mpc_motor_protect_config_reg (.*);
    task wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= 1'h1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
        avs_write <= 1'h0;
        @(posedge clk_sys);
    endtask
    task rd(input logic [7:0] a);
        avs_address <= a;
        avs_read <= 1'h1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
        rv = avs_readdata;
        avs_read <= 1'h0;
        @(posedge clk_sys);
    endtask
    task wrap_up;
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        wt(16);
        rst <= 1'h0;
        rd(mpc_pkg::ADDR_CFG);
        `CHK(rv, 32'h10)
        `CHK(lead_angle, 16'h000F)
        wr(mpc_pkg::ADDR_CFG, 8'hFF);
        rd(mpc_pkg::ADDR_CFG);
        `CHK(rv, 32'hB6)
        `CHK(hall_out, 3'h2)
        wr(8'h30, 8'hFF);
        rd(8'h30);
        `CHK(rv, 32'h0)
        wr(mpc_pkg::ADDR_CFG, 8'h00);
        hall_in <= 3'h6;
        wt(5);
        `CHK(lead_angle, 16'h0500)
        `CHK(hall_out, 3'h6)
        duty_in <= 8'hF0;
        for (int i = 0; i < 2; i++) begin
            overcurrent_in <= 1'h1;
            wt(5);
            `CHK(duty_out, i ? 8'h80 : 8'hF0)
            `CHK(outputs_disable, 1'h1)
            overcurrent_in <= 1'h0;
            wt(5);
            `CHK(outputs_disable, 1'h0)
            wr(mpc_pkg::ADDR_CFG, 8'h80);
        end
        wr(mpc_pkg::ADDR_INT_CLR, 8'h07);
        for (int i = 0; i < 2; i++) begin
            wr(mpc_pkg::ADDR_CFG, i ? 8'h04 : 8'h02);
            wr(mpc_pkg::ADDR_INT_EN, 8'h00);
            if (i)
                rotor_lock_in <= 1'h1;
            else
                overcurrent_in <= 1'h1;
            wt(5);
            overcurrent_in <= 1'h0;
            rotor_lock_in <= 1'h0;
            wt(5);
            `CHK(outputs_disable, 1'h1)
            `CHK(irq, 1'h0)
            rd(mpc_pkg::ADDR_FAULT);
            `CHK(rv, i ? 32'h2 : 32'h1)
            rd(mpc_pkg::ADDR_INT_STAT);
            `CHK(rv, i ? 32'h6 : 32'h5)
            wr(mpc_pkg::ADDR_INT_EN, 8'h07);
            wt(1);
            `CHK(irq, 1'h1)
            reinit <= 1'h1;
            wt(1);
            reinit <= 1'h0;
            wt(2);
            `CHK(outputs_disable, 1'h0)
            wr(mpc_pkg::ADDR_INT_CLR, 8'h07);
            wt(1);
            `CHK(irq, 1'h0)
        end
        otp_value <= 8'h7F;
        otp_load <= 1'h1;
        wt(1);
        otp_load <= 1'h0;
        rd(mpc_pkg::ADDR_CFG);
        `CHK(rv, 32'h36)
        wrap_up();
    end
endmodule
